// [sadi_regs.vh]
`ifndef SADI_REGS_VH
`define SADI_REGS_VH

// instruction byte fields
`define SADI_DIRECT_BIT 7
`define SADI_RD_BIT 6
`define SADI_WIDE_BIT 5
`define SADI_ADDR_HI 2
`define SADI_GAIN_HI 6
`define SADI_GAIN_LO 4
`define SADI_CHAN_HI 3
`define SADI_SE_BIT 3
`define SADI_REV_BIT 2

// synchroniser reset levels: select rests high through its pull-up
`define SADI_SYNC_IDLE 6'h02

// bit counts
`define SADI_BYTE_BITS 4'h8
`define SADI_WORD_BITS 5'h10

// register indices
`define SADI_REG_RES_LO 3'h0
`define SADI_REG_RES_HI 3'h1
`define SADI_REG_STATUS 3'h2
`define SADI_REG_MODE 3'h6
`define SADI_REG_REFOSC 3'h7
`define SADI_MSB_FIRST_BIT 0
`define SADI_OSC_EN_BIT 3
`define SADI_REG_RESET 8'h00

// conversion timing
`define SADI_CONV_TICKS 5'h10
`define SADI_OSC_DIV 4'h9

// gain in tenths
`define SADI_GAIN_0 8'h0a
`define SADI_GAIN_1 8'h12
`define SADI_GAIN_2 8'h24
`define SADI_GAIN_3 8'h2d
`define SADI_GAIN_4 8'h48
`define SADI_GAIN_5 8'h5a
`define SADI_GAIN_6 8'h90
`define SADI_GAIN_7 8'hb4

// result limits
`define SADI_SE_MAX 12'h7ff
`define SADI_SE_MIN 12'h000

`endif

// [sadi_conv.v]
`timescale 1ns/1ps
`default_nettype none
`include "sadi_regs.vh"

module sadi_conv (
  // clock and reset
  input wire clk_sys_in,
  input wire rst_b_in,
  input wire ce_in,
  // command
  input wire start_in,
  input wire [2:0] gain_code_in,
  input wire [3:0] chan_code_in,
  // conversion clock
  input wire conv_clock_source_select_in,
  input wire ext_tick_in,
  input wire osc_en_in,
  // front end
  input wire [11:0] adc_raw_in,
  output reg [2:0] mux_pos_out,
  output reg [2:0] mux_neg_out,
  output reg mux_neg_gnd_out,
  output reg [7:0] gain_x10_out,
  // result
  output reg busy_out,
  output reg done_out,
  output reg overflow_out,
  output reg [11:0] result_out
);

  reg [3:0] div_cnt;
  reg [4:0] tick_cnt;
  reg single_ended;
  reg [7:0] next_gain;
  wire int_tick;
  wire tick;

  // ----------------------------------------
  // conversion clock
  // ----------------------------------------
  assign int_tick = osc_en_in && (div_cnt == `SADI_OSC_DIV);
  assign tick = conv_clock_source_select_in ? int_tick : ext_tick_in;

  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_cnt <= 4'h0;
    end else if (ce_in) begin
      if (!osc_en_in || int_tick) begin
        div_cnt <= 4'h0;
      end else begin
        div_cnt <= div_cnt + 4'h1;
      end
    end
  end

  always @* begin
    case (gain_code_in)
      3'h0: next_gain = `SADI_GAIN_0;
      3'h1: next_gain = `SADI_GAIN_1;
      3'h2: next_gain = `SADI_GAIN_2;
      3'h3: next_gain = `SADI_GAIN_3;
      3'h4: next_gain = `SADI_GAIN_4;
      3'h5: next_gain = `SADI_GAIN_5;
      3'h6: next_gain = `SADI_GAIN_6;
      default: next_gain = `SADI_GAIN_7;
    endcase
  end

  // ----------------------------------------
  // conversion sequence
  // ----------------------------------------
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      overflow_out <= 1'b0;
      result_out <= 12'h000;
      tick_cnt <= 5'h00;
      single_ended <= 1'b0;
      mux_pos_out <= 3'h0;
      mux_neg_out <= 3'h1;
      mux_neg_gnd_out <= 1'b0;
      gain_x10_out <= `SADI_GAIN_0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      if (start_in && !busy_out) begin
        busy_out <= 1'b1;
        tick_cnt <= 5'h00;
        gain_x10_out <= next_gain;
        single_ended <= chan_code_in[`SADI_SE_BIT];
        if (chan_code_in[`SADI_SE_BIT]) begin
          mux_pos_out <= chan_code_in[2:0];
          mux_neg_out <= 3'h0;
          mux_neg_gnd_out <= 1'b1;
        end else begin
          mux_neg_gnd_out <= 1'b0;
          mux_pos_out <= {chan_code_in[1:0], chan_code_in[`SADI_REV_BIT]};
          mux_neg_out <= {chan_code_in[1:0], ~chan_code_in[`SADI_REV_BIT]};
        end
      end else if (busy_out && tick) begin
        if (tick_cnt == `SADI_CONV_TICKS - 5'h01) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          if (single_ended) begin
            overflow_out <= adc_raw_in[11];
            result_out <= adc_raw_in[11] ? `SADI_SE_MIN : {1'b0, adc_raw_in[10:0]};
          end else begin
            overflow_out <= 1'b0;
            result_out <= adc_raw_in;
          end
        end
        tick_cnt <= tick_cnt + 5'h01;
      end
    end
  end

endmodule
`default_nettype wire

// [sadi_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "sadi_regs.vh"

module sadi_top (
  // clock and reset
  input wire clk_sys_in,
  input wire rst_b_in,
  input wire ce_in,
  // serial link
  input wire sclk_in,
  input wire cs_b_in,
  input wire serial_cmd_in,
  input wire edge_select_in,
  output wire serial_result_out,
  output wire serial_result_oe_b_out,
  // conversion clock
  input wire conv_clock_source_select_in,
  input wire conversion_clock_in,
  // analog front end
  input wire [11:0] adc_raw_in,
  output wire [2:0] mux_pos_out,
  output wire [2:0] mux_neg_out,
  output wire mux_neg_gnd_out,
  output wire [7:0] gain_x10_out,
  // status
  output wire busy_out,
  output wire overflow_out,
  output wire msb_first_order_mode_out,
  output wire osc_en_out
);

  localparam ST_INSTR = 3'b001;
  localparam ST_WDATA = 3'b010;
  localparam ST_RDATA = 3'b100;
  localparam NSYNC = 6;
  localparam [NSYNC-1:0] SYNC_IDLE = `SADI_SYNC_IDLE;

  wire [NSYNC-1:0] async_in;
  reg [NSYNC-1:0] sync_a;
  reg [NSYNC-1:0] sync_b;
  reg sclk_d;
  reg conversion_clock_d;
  wire sclk_s;
  wire cs_b_s;
  wire sdi_s;
  wire edge_s;
  wire src_s;
  wire conversion_clock_s;
  wire cap_edge;
  wire launch_edge;
  wire active;

  reg [2:0] state;
  reg [4:0] bit_cnt;
  reg [15:0] in_sr;
  reg [15:0] out_sr;
  reg skip_launch;
  reg wide;
  reg [2:0] addr;
  reg [7:0] regs [0:7];
  reg start;
  reg [2:0] cmd_gain;
  reg [3:0] cmd_chan;
  wire [7:0] byte_in;
  wire [15:0] word_in;
  wire [4:0] len;
  wire [2:0] addr_nx;
  wire msb_first;
  wire conv_done;
  wire [11:0] conv_result;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  assign async_in = {conversion_clock_in, conv_clock_source_select_in, edge_select_in,
                     serial_cmd_in, cs_b_in, sclk_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          // idle levels, so no false select or edge follows reset
          sync_a[gi] <= SYNC_IDLE[gi];
          sync_b[gi] <= SYNC_IDLE[gi];
        end else if (ce_in) begin
          sync_a[gi] <= async_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  assign sclk_s = sync_b[0];
  assign cs_b_s = sync_b[1];
  assign sdi_s = sync_b[2];
  assign edge_s = sync_b[3];
  assign src_s = sync_b[4];
  assign conversion_clock_s = sync_b[5];

  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sclk_d <= 1'b0;
      conversion_clock_d <= 1'b0;
    end else if (ce_in) begin
      sclk_d <= sclk_s;
      conversion_clock_d <= conversion_clock_s;
    end
  end

  // ----------------------------------------
  // edge selection
  // ----------------------------------------
  assign active = !cs_b_s;
  assign cap_edge = active && (edge_s ? (sclk_s && !sclk_d) : (!sclk_s && sclk_d));
  assign launch_edge = active && (edge_s ? (!sclk_s && sclk_d) : (sclk_s && !sclk_d));

  // ----------------------------------------
  // shifter and decode
  // ----------------------------------------
  assign byte_in = {in_sr[6:0], sdi_s};
  assign word_in = {in_sr[14:0], sdi_s};
  assign len = wide ? `SADI_WORD_BITS : {1'b0, `SADI_BYTE_BITS};
  assign addr_nx = addr + 3'h1;
  assign msb_first = regs[`SADI_REG_MODE][`SADI_MSB_FIRST_BIT];

  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= ST_INSTR;
      bit_cnt <= 5'h00;
      in_sr <= 16'h0000;
      out_sr <= 16'h0000;
      skip_launch <= 1'b0;
      wide <= 1'b0;
      addr <= 3'h0;
      start <= 1'b0;
      cmd_gain <= 3'h0;
      cmd_chan <= 4'h0;
    end else if (ce_in) begin
      start <= 1'b0;
      if (!active) begin
        state <= ST_INSTR;
        bit_cnt <= 5'h00;
        skip_launch <= 1'b0;
      end else if (cap_edge) begin
        in_sr <= word_in;
        bit_cnt <= bit_cnt + 5'h01;
        case (state)
          ST_INSTR: begin
            if (bit_cnt == {1'b0, `SADI_BYTE_BITS} - 5'h01) begin
              bit_cnt <= 5'h00;
              if (byte_in[`SADI_DIRECT_BIT]) begin
                start <= 1'b1;
                cmd_gain <= byte_in[`SADI_GAIN_HI:`SADI_GAIN_LO];
                cmd_chan <= byte_in[`SADI_CHAN_HI:0];
              end else begin
                wide <= byte_in[`SADI_WIDE_BIT];
                addr <= byte_in[`SADI_ADDR_HI:0];
                if (byte_in[`SADI_RD_BIT]) begin
                  state <= ST_RDATA;
                  skip_launch <= 1'b1;
                  if (!byte_in[`SADI_WIDE_BIT]) begin
                    out_sr <= {regs[byte_in[`SADI_ADDR_HI:0]], 8'h00};
                  end else if (msb_first) begin
                    out_sr <= {regs[byte_in[`SADI_ADDR_HI:0] + 3'h1],
                               regs[byte_in[`SADI_ADDR_HI:0]]};
                  end else begin
                    out_sr <= {regs[byte_in[`SADI_ADDR_HI:0]],
                               regs[byte_in[`SADI_ADDR_HI:0] + 3'h1]};
                  end
                end else begin
                  state <= ST_WDATA;
                end
              end
            end
          end
          ST_WDATA: begin
            if (bit_cnt == len - 5'h01) begin
              bit_cnt <= 5'h00;
              state <= ST_INSTR;
            end
          end
          ST_RDATA: begin
            if (bit_cnt == len - 5'h01) begin
              bit_cnt <= 5'h00;
              state <= ST_INSTR;
            end
          end
          default: begin
            state <= ST_INSTR;
            bit_cnt <= 5'h00;
          end
        endcase
      end else if (launch_edge && (state == ST_RDATA)) begin
        skip_launch <= 1'b0;
        if (!skip_launch) begin
          out_sr <= {out_sr[14:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  wire wr_done;
  assign wr_done = active && cap_edge && (state == ST_WDATA) && (bit_cnt == len - 5'h01);

  genvar ri;
  generate
    for (ri = 0; ri < 8; ri = ri + 1) begin : g_reg
      always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          regs[ri] <= 8'h00;
        end else if (ce_in) begin
          if (ri == `SADI_REG_RES_LO && conv_done) begin
            regs[ri] <= conv_result[7:0];
          end else if (ri == `SADI_REG_RES_HI && conv_done) begin
            regs[ri] <= {{4{conv_result[11]}}, conv_result[11:8]};
          end else if (ri == `SADI_REG_STATUS) begin
            regs[ri] <= {6'h00, overflow_out, busy_out};
          end else if (wr_done && !wide && addr == `SADI_REG_RES_LO &&
                       byte_in == `SADI_REG_RESET) begin
            regs[ri] <= 8'h00;
          end else if (wr_done && ri > `SADI_REG_STATUS) begin
            if (!wide && addr == ri) begin
              regs[ri] <= byte_in;
            end else if (wide && addr == ri) begin
              regs[ri] <= msb_first ? word_in[7:0] : word_in[15:8];
            end else if (wide && addr_nx == ri) begin
              regs[ri] <= msb_first ? word_in[15:8] : word_in[7:0];
            end
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // conversion engine
  // ----------------------------------------
  sadi_conv u_conv (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .start_in(start),
    .gain_code_in(cmd_gain),
    .chan_code_in(cmd_chan),
    .conv_clock_source_select_in(src_s),
    .ext_tick_in(conversion_clock_s && !conversion_clock_d),
    .osc_en_in(osc_en_out),
    .adc_raw_in(adc_raw_in),
    .mux_pos_out(mux_pos_out),
    .mux_neg_out(mux_neg_out),
    .mux_neg_gnd_out(mux_neg_gnd_out),
    .gain_x10_out(gain_x10_out),
    .busy_out(busy_out),
    .done_out(conv_done),
    .overflow_out(overflow_out),
    .result_out(conv_result)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign serial_result_out = out_sr[15];
  assign serial_result_oe_b_out = cs_b_s;
  assign msb_first_order_mode_out = msb_first;
  assign osc_en_out = regs[`SADI_REG_REFOSC][`SADI_OSC_EN_BIT];

endmodule
`default_nettype wire

// [sadi_top_props.sv]
`timescale 1ns/1ps
`default_nettype none
module sadi_top_props (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // serial link
  input wire logic cs_b_in,
  input wire logic serial_result_oe_b_out,
  // front end and status
  input wire logic [2:0] mux_pos_out,
  input wire logic [2:0] mux_neg_out,
  input wire logic mux_neg_gnd_out,
  input wire logic [7:0] gain_x10_out,
  input wire logic busy_out,
  input wire logic overflow_out,
  input wire logic osc_en_out
);
  logic [9:0] busy_len;
  // counts cycles of the running conversion
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in)
      busy_len <= 10'h000;
    else if (!busy_out)
      busy_len <= 10'h000;
    else if (busy_len != 10'h3ff)
      busy_len <= busy_len + 10'h001;
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  a_start_needs_select: assert property (
    $rose(busy_out) |-> !$past(cs_b_in, 5)) else $error("busy rose without select");
  a_busy_min_len: assert property (
    $fell(busy_out) |-> busy_len >= 10'd32) else $error("conversion too short");
  a_busy_max_len: assert property (
    busy_len <= 10'd400) else $error("conversion too long");
  a_sel_hold: assert property (
    busy_out && $past(busy_out) |-> $stable({mux_pos_out, mux_neg_out, mux_neg_gnd_out,
    gain_x10_out})) else $error("selection changed during conversion");
  a_gain_legal: assert property (
    gain_x10_out inside {8'h0a, 8'h12, 8'h24, 8'h2d, 8'h48, 8'h5a, 8'h90, 8'hb4})
    else $error("gain value not in table");
  a_oe_idle: assert property (
    cs_b_in [*4] |-> serial_result_oe_b_out) else $error("output driven while idle");
  a_oe_selected: assert property (
    (!cs_b_in) [*4] |-> !serial_result_oe_b_out) else $error("output not driven");
  a_no_start_idle: assert property (
    cs_b_in [*8] |-> !$rose(busy_out)) else $error("start while deselected");
  a_osc_via_link: assert property (
    $rose(osc_en_out) |-> !$past(cs_b_in, 3)) else $error("osc enable outside frame");
  a_ovf_single: assert property (
    $rose(overflow_out) |-> mux_neg_gnd_out) else $error("overflow on differential");
endmodule
bind sadi_top sadi_top_props u_sadi_top_props (.clk_sys_in, .rst_b_in, .cs_b_in,
  .serial_result_oe_b_out, .mux_pos_out, .mux_neg_out, .mux_neg_gnd_out, .gain_x10_out,
  .busy_out, .overflow_out, .osc_en_out);
`default_nettype wire

// [sadi_host.sv]
`timescale 1ns/1ps
`default_nettype none
module sadi_host (
  // clock and link
  input wire logic clk_sys_in,
  input wire logic serial_result_in,
  output logic sclk_out,
  output logic cs_b_out,
  output logic serial_cmd_out,
  // read result
  output logic [15:0] rx_word_out,
  output logic rx_strobe_out
);
  initial begin
    sclk_out = 1'b0;
    cs_b_out = 1'b1;
    serial_cmd_out = 1'b1;
    rx_word_out = 16'h0000;
    rx_strobe_out = 1'b0;
  end
  task automatic half_bit;
    repeat (8) @(posedge clk_sys_in);
    #1;
  endtask
  // frame of n bits, msb first; read bits taken at each falling edge after the first 8 bits
  task automatic xfer(input logic [23:0] tx, input int n, input logic rd);
    cs_b_out = 1'b0;
    rx_word_out = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      serial_cmd_out = tx[i];
      half_bit();
      sclk_out = 1'b1;
      half_bit();
      if (rd && i <= n - 9)
        rx_word_out = {rx_word_out[14:0], serial_result_in};
      sclk_out = 1'b0;
    end
    half_bit();
    cs_b_out = 1'b1;
    serial_cmd_out = ~serial_cmd_out;
    rx_strobe_out = rd;
    @(posedge clk_sys_in);
    #1;
    rx_strobe_out = 1'b0;
    half_bit();
  endtask
endmodule
`default_nettype wire

// [sadi_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module sadi_top_bench;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic src_sel = 1'b1;
  logic conv_clk = 1'b0;
  logic [11:0] raw = 12'h000;
  logic sclk, cs_b, cmd, res, oe_b, gnd, busy, ovf, msbf, osc, rx_stb;
  logic busy_d = 1'b0;
  logic [2:0] mpos, mneg;
  logic [7:0] gain;
  logic [15:0] rx_word;
  logic [15:0] lfsr = 16'h005c;
  logic [29:0] n_sel;
  logic [15:0] q_rd[$];
  logic [29:0] q_sel[$];
  logic [7:0] gtab [8] = '{8'h0a, 8'h12, 8'h24, 8'h2d, 8'h48, 8'h5a, 8'h90, 8'hb4};
  int fail_count = 0;
  int compares = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  always #20 conv_clk = ~conv_clk;
  sadi_top u_sadi_top (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .ce_in(1'b1),
    .sclk_in(sclk), .cs_b_in(cs_b), .serial_cmd_in(cmd), .edge_select_in(1'b1),
    .serial_result_out(res), .serial_result_oe_b_out(oe_b),
    .conv_clock_source_select_in(src_sel), .conversion_clock_in(conv_clk),
    .adc_raw_in(raw), .mux_pos_out(mpos), .mux_neg_out(mneg), .mux_neg_gnd_out(gnd),
    .gain_x10_out(gain), .busy_out(busy), .overflow_out(ovf),
    .msb_first_order_mode_out(msbf), .osc_en_out(osc));
  // a released output pin shows the inverse of its last value
  sadi_host u_sadi_host (.clk_sys_in(clk_sys_in), .serial_result_in(oe_b ? ~res : res),
    .sclk_out(sclk),
    .cs_b_out(cs_b), .serial_cmd_out(cmd), .rx_word_out(rx_word), .rx_strobe_out(rx_stb));
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // compares each result against the oldest note
  always @(posedge clk_sys_in) begin
    busy_d <= busy;
    if (rx_stb === 1'b1 && q_rd.size() > 0)
      chk(rx_word, q_rd.pop_front());
    if (busy === 1'b1 && busy_d === 1'b0 && q_sel.size() > 0) begin
      n_sel = q_sel.pop_front();
      chk({1'b0, {gnd, mpos, mneg, gain} & n_sel[29:15]}, {1'b0, n_sel[14:0]});
    end
  end
  task automatic conv(input logic [7:0] c);
    logic [11:0] r;
    logic [7:0] g;
    lfsr = lfsr_next(lfsr);
    r = lfsr[11:0];
    g = gtab[c[6:4]];
    raw = r;
    if (c[3]) begin
      q_sel.push_back({15'h78ff, 1'b1, c[2:0], 3'h0, g});
      q_rd.push_back(r[11] ? 16'h0000 : {5'h00, r[10:0]});
    end else begin
      q_sel.push_back({15'h7fff, 1'b0, c[1:0], c[2], c[1:0], ~c[2], g});
      q_rd.push_back({{4{r[11]}}, r});
    end
    u_sadi_host.xfer({16'h0000, c}, 8, 1'b0);
    for (int k = 0; k < 400 && busy !== 1'b0; k++) begin
      @(posedge clk_sys_in);
      #1;
    end
    chk({14'h0, busy, ovf}, {15'h0, c[3] & r[11]});
    u_sadi_host.xfer(24'h600000, 24, 1'b1);
  endtask
  initial begin
    #150000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge clk_sys_in);
    #1;
    chk({15'h0, oe_b}, 16'h0001);
    rst_b_in = 1'b1;
    // start-up settling wait, scaled down for simulation
    u_sadi_host.half_bit();
    u_sadi_host.xfer(24'h000601, 16, 1'b0);
    u_sadi_host.xfer(24'h000708, 16, 1'b0);
    u_sadi_host.xfer(24'h000155, 16, 1'b0);
    chk({14'h0, msbf, osc}, 16'h0003);
    q_rd.push_back(16'h0008);
    u_sadi_host.xfer(24'h004700, 16, 1'b1);
    q_rd.push_back(16'h0000);
    u_sadi_host.xfer(24'h004100, 16, 1'b1);
    u_sadi_host.xfer(24'h23a55a, 24, 1'b0);
    q_rd.push_back(16'ha55a);
    u_sadi_host.xfer(24'h630000, 24, 1'b1);
    $display("test registers finished");
    u_sadi_host.xfer(24'h000008, 4, 1'b0);
    repeat (40) @(posedge clk_sys_in);
    #1;
    chk({15'h0, busy}, 16'h0000);
    $display("test aborted frame finished");
    for (int i = 0; i < 16; i++) begin
      src_sel = ~i[0];
      conv({1'b1, i[2:0], i[3:0]});
    end
    $display("test conversions finished");
    u_sadi_host.xfer(24'h000000, 16, 1'b0);
    chk({14'h0, msbf, osc}, 16'h0000);
    $display("test register clear finished");
    report_and_stop();
  end
endmodule
`default_nettype wire
